/* host_bus_defs.svh */
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH

// Widths of the host bus and of the internal data paths.
`define HB_HALF_W 16
`define HB_WORD_W 32
`define HB_ADDR_W 7
`define HB_WADDR_W 6

// Word address windows, A[7:2]: RX data port, TX data port, control/status space.
`define HB_RXDATA_WORD 6'h00
`define HB_TXDATA_WORD 6'h08
`define HB_CSR_BASE 6'h10

// Field positions inside the pin address A[7:1].
`define HB_HALF_BIT 0
`define HB_REGION_MSB 6
`define HB_REGION_LSB 5

// Reset values of the strap registers and of the interrupt hold-off width.
`define HB_STRAP_SPEED_RESET 1'b1
`define HB_STRAP_XOVER_RESET 1'b0
`define HB_HOLDOFF_W 8

`endif

/* host_bus_pkg.sv */
package host_bus_pkg;

   // Host access sequencer, one-hot.
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h1,
      ST_READ  = 3'h2,
      ST_WRITE = 3'h4
   } access_state_e;

   // Destination selected by the address decoder.
   typedef enum logic [1:0]
   {
      TGT_RX  = 2'h0,
      TGT_TX  = 2'h1,
      TGT_CSR = 2'h2
   } target_e;

endpackage : host_bus_pkg

/* stream_if.sv */
// Valid/ready word stream between the host port and its buffer.
interface stream_if #(parameter int WIDTH = 32);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : stream_if

/* word_buffer.sv */
// Small FIFO that holds words while the receiver stalls.
module word_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Filling side.
   stream_if.sink   fill,
   // Draining side.
   stream_if.source drain
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wrPtr_reg;
   logic [PW-1:0]    wrPtr_next;
   logic [PW-1:0]    rdPtr_reg;
   logic [PW-1:0]    rdPtr_next;
   logic [PW:0]      count_reg;
   logic [PW:0]      count_next;
   logic             push;
   logic             pop;

   // Honest full and empty drive both handshakes.
   assign fill.ready  = (count_reg != (PW+1)'(DEPTH));
   assign drain.valid = (count_reg != '0);
   assign drain.data  = store[rdPtr_reg];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   // Pointer and occupancy update.
   always_comb
   begin
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      count_next = count_reg;
      if (push)
      begin
         wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_reg + 1'b1);
      end
      if (pop)
      begin
         rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_reg + 1'b1);
      end
      if (push && !pop)
      begin
         count_next = (PW+1)'(count_reg + 1'b1);
      end
      else if (pop && !push)
      begin
         count_next = (PW+1)'(count_reg - 1'b1);
      end
   end

   // Registers the pointers and writes the storage.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
      if (push)
      begin
         store[wrPtr_reg] <= fill.data;
      end
   end

endmodule : word_buffer

/* irq_pin.sv */
`include "host_bus_defs.svh"

// Interrupt pin driver with polarity, buffer type and de-assertion hold-off.
module irq_pin #(
   parameter int HW = `HB_HOLDOFF_W
) (
   // Clock and reset.
   input  wire logic          mclk,
   input  wire logic          rst,
   // Request and configuration.
   input  wire logic          irqRequest,
   input  wire logic          polarityHigh,
   input  wire logic          pushPull,
   input  wire logic [HW-1:0] holdoffCycles,
   // Pin.
   output logic               irqOut,
   output logic               irqOeLow,
   output logic               irqAsserted
);
   logic          asserted_reg;
   logic          asserted_next;
   logic [HW-1:0] holdoff_reg;
   logic [HW-1:0] holdoff_next;

   // Asserts only once the hold-off count has run out after a de-assertion.
   always_comb
   begin
      asserted_next = asserted_reg;
      holdoff_next  = holdoff_reg;
      if (holdoff_reg != '0)
      begin
         holdoff_next = HW'(holdoff_reg - 1'b1);
      end
      if (asserted_reg && !irqRequest)
      begin
         asserted_next = 1'b0;
         holdoff_next  = holdoffCycles;
      end
      else if (!asserted_reg && irqRequest && holdoff_reg == '0)
      begin
         asserted_next = 1'b1;
      end
   end

   // Registers the pin state.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         asserted_reg <= 1'b0;
         holdoff_reg  <= '0;
      end
      else
      begin
         asserted_reg <= asserted_next;
         holdoff_reg  <= holdoff_next;
      end
   end

   // Push-pull always drives; open-drain drives only while asserted.
   assign irqOut      = pushPull ? (asserted_reg ~^ polarityHigh) : polarityHigh;
   assign irqOeLow    = pushPull ? 1'b0 : !asserted_reg;
   assign irqAsserted = asserted_reg;

endmodule : irq_pin

/* host_bus_unit.sv */
`include "host_bus_defs.svh"

module host_bus_unit
   import host_bus_pkg::*;
#(
   parameter int TX_DEPTH = 2,
   parameter int HW       = `HB_HOLDOFF_W
) (
   // Clock and reset.
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // Host bus pins.
   input  wire logic [`HB_ADDR_W-1:0]   addrIn,
   input  wire logic                    chipSelectLow,
   input  wire logic                    readStrobeLow,
   input  wire logic                    writeStrobeLow,
   input  wire logic                    fifoSelect,
   input  wire logic [`HB_HALF_W-1:0]   dataIn,
   output logic      [`HB_HALF_W-1:0]   dataOut,
   output logic                         dataOeLow,
   // Interrupt pin and its configuration.
   input  wire logic                    irqSource,
   input  wire logic                    irqPolarityHigh,
   input  wire logic                    irqPushPull,
   input  wire logic [HW-1:0]           irqHoldoffCycles,
   output logic                         irqOut,
   output logic                         irqOeLow,
   output logic                         irqActive,
   // Configuration and power.
   input  wire logic                    bigEndian,
   input  wire logic                    lowPowerState,
   output logic                         wakeRequest,
   // Straps and resulting defaults.
   input  wire logic                    speedSelect,
   input  wire logic                    crossoverDetectEnable,
   output logic                         default100Mbps,
   output logic                         defaultFullDuplex,
   output logic                         defaultAutoNeg,
   output logic                         autoCrossoverOn,
   // Control/status register access.
   output logic      [`HB_WADDR_W-1:0]  csrAddr,
   output logic                         csrReadStrobe,
   input  wire logic [`HB_WORD_W-1:0]   csrReadData,
   output logic                         csrWriteStrobe,
   output logic      [`HB_WORD_W-1:0]   csrWriteData,
   // RX data FIFO.
   input  wire logic                    rxValid,
   input  wire logic [`HB_WORD_W-1:0]   rxData,
   output logic                         rxReady,
   // TX data FIFO.
   output logic                         txValid,
   output logic      [`HB_WORD_W-1:0]   txData,
   input  wire logic                    txReady,
   output logic                         txDropped
);
   access_state_e               state_reg;
   access_state_e               state_next;
   logic                        csActive;
   logic                        readReq;
   logic                        writeReq;
   logic                        halfSel;
   logic [`HB_WADDR_W-1:0]      wordAddr;
   target_e                     target;
   logic                        readEntry;
   logic [`HB_WORD_W-1:0]       fetchWord;
   logic [`HB_WORD_W-1:0]       readWord_reg;
   logic [`HB_WORD_W-1:0]       readWord_next;
   logic [`HB_HALF_W-1:0]       dataOut_reg;
   logic [`HB_HALF_W-1:0]       dataOut_next;
   logic [`HB_HALF_W-1:0]       wrHalf_reg;
   logic [`HB_HALF_W-1:0]       wrHalf_next;
   logic [`HB_ADDR_W-1:0]       wrAddr_reg;
   logic [`HB_ADDR_W-1:0]       wrAddr_next;
   target_e                     wrTarget_reg;
   target_e                     wrTarget_next;
   logic                        wrLive_reg;
   logic                        wrLive_next;
   logic [`HB_WORD_W-1:0]       wrWord_reg;
   logic [`HB_WORD_W-1:0]       wrWord_next;
   logic [`HB_WORD_W-1:0]       merged;
   logic                        wrLowLane;
   logic                        txPush_reg;
   logic                        txPush_next;
   logic                        txDrop_reg;
   logic                        txDrop_next;
   logic                        csrWr_reg;
   logic                        csrWr_next;
   logic [`HB_WADDR_W-1:0]      csrWrAddr_reg;
   logic [`HB_WADDR_W-1:0]      csrWrAddr_next;
   logic                        wake_reg;
   logic                        wake_next;
   logic                        strapDone_reg;
   logic                        strapDone_next;
   logic                        speedStrap_reg;
   logic                        speedStrap_next;
   logic                        xover_reg;
   logic                        xover_next;

   stream_if #(.WIDTH(`HB_WORD_W)) txIn ();
   stream_if #(.WIDTH(`HB_WORD_W)) txOut ();

   // Qualifies the strobes with chip select; read wins if both are low.
   assign csActive = !chipSelectLow;
   assign readReq  = csActive && !readStrobeLow;
   assign writeReq = csActive && !writeStrobeLow;
   assign halfSel  = addrIn[`HB_HALF_BIT];
   assign wordAddr = addrIn[`HB_ADDR_W-1:1];

   // Decodes the destination of the current access.
   always_comb
   begin
      if (fifoSelect)
      begin
         target = readReq ? TGT_RX : TGT_TX;
      end
      else if (addrIn[`HB_REGION_MSB:`HB_REGION_LSB] != '0)
      begin
         target = TGT_CSR;
      end
      else if (wordAddr >= `HB_TXDATA_WORD)
      begin
         target = TGT_TX;
      end
      else
      begin
         target = TGT_RX;
      end
   end

   // A read fetches a whole word on its first half and pops the RX FIFO once.
   assign readEntry     = (state_reg == ST_IDLE) && readReq;
   assign rxReady       = readEntry && !halfSel && target == TGT_RX && rxValid;
   assign csrReadStrobe = readEntry && !halfSel && target == TGT_CSR;
   assign csrAddr       = csrWr_reg ? csrWrAddr_reg : wordAddr;
   assign fetchWord     = (target == TGT_CSR) ? csrReadData : ((target == TGT_RX && rxValid) ? rxData : '0);

   // Access sequencer: one strobe assertion is one 16-bit transfer.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (readReq)
            begin
               state_next = ST_READ;
            end
            else if (writeReq)
            begin
               state_next = ST_WRITE;
            end
         end
         ST_READ:
         begin
            if (!readReq)
            begin
               state_next = ST_IDLE;
            end
         end
         ST_WRITE:
         begin
            if (!writeReq)
            begin
               state_next = ST_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Read data: the first half fetches and splits the word, the second replays it.
   always_comb
   begin
      readWord_next = readWord_reg;
      dataOut_next  = dataOut_reg;
      if (readEntry)
      begin
         if (!halfSel)
         begin
            readWord_next = fetchWord;
            dataOut_next  = bigEndian ? fetchWord[31:16] : fetchWord[15:0];
         end
         else
         begin
            dataOut_next = bigEndian ? readWord_reg[15:0] : readWord_reg[31:16];
         end
      end
   end

   // Write data is taken on the trailing edge of the strobe, as an SRAM would.
   assign wrLowLane = (wrAddr_reg[`HB_HALF_BIT] == bigEndian);
   assign merged    = wrLowLane ? {wrWord_reg[31:16], wrHalf_reg} : {wrHalf_reg, wrWord_reg[15:0]};

   // Write capture and commit; a word leaves only when its second half lands.
   always_comb
   begin
      wrHalf_next    = wrHalf_reg;
      wrAddr_next    = wrAddr_reg;
      wrTarget_next  = wrTarget_reg;
      wrLive_next    = wrLive_reg;
      wrWord_next    = wrWord_reg;
      txPush_next    = 1'b0;
      txDrop_next    = 1'b0;
      csrWr_next     = 1'b0;
      csrWrAddr_next = csrWrAddr_reg;
      wake_next      = 1'b0;
      if (state_reg == ST_IDLE && !readReq && writeReq)
      begin
         wrLive_next = !lowPowerState;
         wake_next   = lowPowerState;
      end
      if (state_reg == ST_WRITE && writeReq)
      begin
         wrHalf_next   = dataIn;
         wrAddr_next   = addrIn;
         wrTarget_next = target;
      end
      if (state_reg == ST_WRITE && !writeReq && wrLive_reg)
      begin
         wrWord_next = merged;
         if (wrAddr_reg[`HB_HALF_BIT])
         begin
            if (wrTarget_reg == TGT_TX)
            begin
               txPush_next = txIn.ready;
               txDrop_next = !txIn.ready;
            end
            else if (wrTarget_reg == TGT_CSR)
            begin
               csrWr_next     = 1'b1;
               csrWrAddr_next = wrAddr_reg[`HB_ADDR_W-1:1];
            end
         end
      end
   end

   // Straps: speed is caught on the first clock after reset release and then held.
   always_comb
   begin
      strapDone_next  = 1'b1;
      speedStrap_next = strapDone_reg ? speedStrap_reg : speedSelect;
      xover_next      = crossoverDetectEnable;
   end

   // Registers every group of state.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_reg      <= ST_IDLE;
         readWord_reg   <= '0;
         dataOut_reg    <= '0;
         wrHalf_reg     <= '0;
         wrAddr_reg     <= '0;
         wrTarget_reg   <= TGT_RX;
         wrLive_reg     <= 1'b0;
         wrWord_reg     <= '0;
         txPush_reg     <= 1'b0;
         txDrop_reg     <= 1'b0;
         csrWr_reg      <= 1'b0;
         csrWrAddr_reg  <= '0;
         wake_reg       <= 1'b0;
         strapDone_reg  <= 1'b0;
         speedStrap_reg <= `HB_STRAP_SPEED_RESET;
         xover_reg      <= `HB_STRAP_XOVER_RESET;
      end
      else
      begin
         state_reg      <= state_next;
         readWord_reg   <= readWord_next;
         dataOut_reg    <= dataOut_next;
         wrHalf_reg     <= wrHalf_next;
         wrAddr_reg     <= wrAddr_next;
         wrTarget_reg   <= wrTarget_next;
         wrLive_reg     <= wrLive_next;
         wrWord_reg     <= wrWord_next;
         txPush_reg     <= txPush_next;
         txDrop_reg     <= txDrop_next;
         csrWr_reg      <= csrWr_next;
         csrWrAddr_reg  <= csrWrAddr_next;
         wake_reg       <= wake_next;
         strapDone_reg  <= strapDone_next;
         speedStrap_reg <= speedStrap_next;
         xover_reg      <= xover_next;
      end
   end

   // Data bus drive follows the qualified read strobe only; no DMA master exists.
   assign dataOut   = dataOut_reg;
   assign dataOeLow = !readReq;

   // Completed TX words enter the buffer, which drains to the TX FIFO.
   assign txIn.valid     = txPush_reg;
   assign txIn.data      = wrWord_reg;
   assign txValid        = txOut.valid;
   assign txData         = txOut.data;
   assign txOut.ready    = txReady;
   assign txDropped      = txDrop_reg;
   assign csrWriteStrobe = csrWr_reg;
   assign csrWriteData   = wrWord_reg;
   assign wakeRequest    = wake_reg;

   // Default speed and auto-negotiation from the held strap; full duplex tied off; crossover follows its input.
   assign default100Mbps    = speedStrap_reg;
   assign defaultFullDuplex = 1'b0;
   assign defaultAutoNeg    = speedStrap_reg;
   assign autoCrossoverOn   = xover_reg;

   // Buffer between the host port and the TX FIFO.
   word_buffer #(
      .WIDTH (`HB_WORD_W),
      .DEPTH (TX_DEPTH)
   ) txBuffer (
      .mclk  (mclk),
      .rst   (rst),
      .fill  (txIn),
      .drain (txOut)
   );

   // Interrupt pin with hold-off.
   irq_pin #(
      .HW (HW)
   ) irqDriver (
      .mclk          (mclk),
      .rst           (rst),
      .irqRequest    (irqSource),
      .polarityHigh  (irqPolarityHigh),
      .pushPull      (irqPushPull),
      .holdoffCycles (irqHoldoffCycles),
      .irqOut        (irqOut),
      .irqOeLow      (irqOeLow),
      .irqAsserted   (irqActive)
   );

endmodule : host_bus_unit

/* host_bus_assertions.sv */
`include "host_bus_defs.svh"

// Checks pin timing, straps and interrupt pin of the host bus unit.
module host_bus_assertions #(
   parameter int HW = `HB_HOLDOFF_W
) (
   // Clock and reset.
   input wire logic          mclk,
   input wire logic          rst,
   // Host bus and internal strobes.
   input wire logic          chipSelectLow,
   input wire logic          readStrobeLow,
   input wire logic          writeStrobeLow,
   input wire logic          dataOeLow,
   input wire logic          rxReady,
   input wire logic          csrReadStrobe,
   input wire logic          csrWriteStrobe,
   input wire logic          lowPowerState,
   input wire logic          wakeRequest,
   // Interrupt.
   input wire logic          irqSource,
   input wire logic          irqPolarityHigh,
   input wire logic          irqPushPull,
   input wire logic [HW-1:0] irqHoldoffCycles,
   input wire logic          irqOut,
   input wire logic          irqOeLow,
   input wire logic          irqActive,
   // Straps.
   input wire logic          crossoverDetectEnable,
   input wire logic          default100Mbps,
   input wire logic          defaultFullDuplex,
   input wire logic          defaultAutoNeg,
   input wire logic          autoCrossoverOn
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic [HW:0] offCnt_reg;
   logic [HW:0] offCnt_next;

   // Counts inactive interrupt cycles, saturating above any hold-off value.
   always_comb
   begin
      offCnt_next = offCnt_reg;
      if (irqActive)
         offCnt_next = '0;
      else if (!offCnt_reg[HW])
         offCnt_next = offCnt_reg + 1'b1;
   end

   // Registers the counter; reset starts it saturated.
   always_ff @(posedge mclk)
   begin
      offCnt_reg <= rst ? {1'b1, {HW{1'b0}}} : offCnt_next;
   end

   // A read is taken only while selected with the read strobe low.
   sequence readTaken;
      !chipSelectLow && !readStrobeLow;
   endsequence

   a_oe_drive: assert property (dataOeLow == (chipSelectLow || readStrobeLow))
      else $error("data bus drive does not follow select and read strobe");
   a_rd_pop: assert property ((rxReady || csrReadStrobe) |-> readTaken)
      else $error("read fetch without a selected read strobe");
   a_wr_commit: assert property (csrWriteStrobe |->
      $past(chipSelectLow || writeStrobeLow) && !$past(chipSelectLow || writeStrobeLow, 2))
      else $error("register write not one cycle after a write ended");
   a_wake_pulse: assert property (wakeRequest |->
      $past(lowPowerState && !chipSelectLow && !writeStrobeLow) ##1 !wakeRequest)
      else $error("wake pulse without a selected write in low power");
   a_irq_pp: assert property (irqPushPull && $stable(irqPushPull) && $stable(irqPolarityHigh) |->
      !irqOeLow && irqOut == (irqActive ~^ irqPolarityHigh))
      else $error("push-pull interrupt pin level wrong");
   a_irq_od: assert property (!irqPushPull && $stable(irqPushPull) && $stable(irqPolarityHigh) |->
      irqOeLow == !irqActive && irqOut == irqPolarityHigh)
      else $error("open-drain interrupt pin wrong");
   a_irq_cause: assert property ($rose(irqActive) |-> $past(irqSource))
      else $error("interrupt asserted without a request");
   a_irq_drop: assert property (irqActive && !irqSource |=> !irqActive)
      else $error("interrupt not released after request dropped");
   a_irq_holdoff: assert property ($rose(irqActive) && $stable(irqHoldoffCycles) |->
      offCnt_reg >= irqHoldoffCycles)
      else $error("interrupt asserted inside hold-off interval");
   a_strap_hold: assert property (!$past(rst) && !$past(rst, 2) |->
      $stable(default100Mbps) && $stable(defaultAutoNeg))
      else $error("latched strap changed");
   a_strap_map: assert property (default100Mbps == defaultAutoNeg && !defaultFullDuplex)
      else $error("default settings inconsistent");
   a_xover_follow: assert property (!$past(rst) |-> autoCrossoverOn == $past(crossoverDetectEnable))
      else $error("crossover detect does not follow its input");
endmodule : host_bus_assertions

/* host_model.sv */
// Embedded host making SRAM-like programmed I/O cycles.
module host_model (
   // Clock.
   input  wire logic        mclk,
   // Bus lines driven by the host.
   output logic [6:0]       addrIn,
   output logic             chipSelectLow,
   output logic             readStrobeLow,
   output logic             writeStrobeLow,
   output logic [15:0]      hostData,
   // Resolved data bus.
   input  wire logic [15:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus starts idle with nothing selected.
   initial
   begin
      addrIn = '0;
      {chipSelectLow, readStrobeLow, writeStrobeLow} = 3'h7;
      hostData = '0;
   end

   // One cycle: strobe held two clocks, then lines released and two idle clocks.
   task automatic access(input logic wr, input logic sel, input logic [6:0] a,
                         input logic [15:0] d, output logic [15:0] q);
      @(negedge mclk);
      addrIn = a;
      hostData = d;
      chipSelectLow = !sel;
      readStrobeLow = wr;
      writeStrobeLow = !wr;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      q = dataIn;
      {chipSelectLow, readStrobeLow, writeStrobeLow} = 3'h7;
      hostData = ~d;
      addrIn = ~a;
      repeat (2) @(negedge mclk);
   endtask : access
endmodule : host_model

/* tb_top.sv */
bind host_bus_unit host_bus_assertions #(.HW(HW)) host_bus_assertions_inst (.*);

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk, rst, chipSelectLow, readStrobeLow, writeStrobeLow, fifoSelect, dataOeLow;
   logic irqSource, irqPolarityHigh, irqPushPull, irqOut, irqOeLow, irqActive;
   logic bigEndian, lowPowerState, wakeRequest, speedSelect, crossoverDetectEnable;
   logic default100Mbps, defaultFullDuplex, defaultAutoNeg, autoCrossoverOn;
   logic csrReadStrobe, csrWriteStrobe, rxValid, rxReady, txValid, txReady, txDropped;
   logic [6:0]  addrIn;
   logic [5:0]  csrAddr, rdAddr;
   logic [7:0]  irqHoldoffCycles;
   logic [15:0] dataIn, dataOut, hostData;
   logic [31:0] csrReadData, csrWriteData, rxData, txData;
   logic [31:0] txExp[$], txGot[$];
   logic [37:0] csrGot[$];
   int err_count, n_tests, cycles, pops, drops, wakes;

   // The device wins the data bus while it drives it.
   assign dataIn = dataOeLow ? hostData : dataOut;

   host_bus_unit #(.TX_DEPTH(2), .HW(8)) host_bus_unit_inst (.*);
   host_model host_model_inst (.*);

   // Free-running clock.
   initial
   begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end

   // Records results handed to the CSR space, the TX side and the power logic.
   always @(posedge mclk)
   begin
      cycles++;
      if (csrWriteStrobe) csrGot.push_back({csrAddr, csrWriteData});
      if (csrReadStrobe) rdAddr = csrAddr;
      if (txValid && txReady) txGot.push_back(txData);
      pops += rxReady;
      drops += txDropped;
      wakes += wakeRequest;
      if (cycles == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [37:0] got, input logic [37:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task automatic doReset();
      rst = 1;
      repeat (2) @(negedge mclk);
      rst = 0;
   endtask : doReset

   // Word access as two halves; the endian setting decides which half goes first.
   task automatic wordWr(input logic [5:0] wa, input logic [31:0] w, input logic sel);
      logic [15:0] q;
      for (int h = 0; h < 2; h++)
         host_model_inst.access(1'b1, sel, {wa, h[0]}, (h[0] ^ bigEndian) ? w[31:16] : w[15:0], q);
   endtask : wordWr

   task automatic wordRd(input logic [5:0] wa, output logic [31:0] r);
      logic [15:0] q;
      for (int h = 0; h < 2; h++)
      begin
         host_model_inst.access(1'b0, 1'b1, {wa, h[0]}, 16'h0000, q);
         if (h[0] ^ bigEndian) r[31:16] = q;
         else r[15:0] = q;
      end
   endtask : wordRd

   // Main sequence of tests.
   initial
   begin
      logic [31:0] w, r;
      logic [5:0]  wa;
      {rst, fifoSelect, irqSource, irqPolarityHigh, irqPushPull, bigEndian, lowPowerState} = 7'h40;
      {speedSelect, crossoverDetectEnable, rxValid, txReady} = 4'h0;
      {irqHoldoffCycles, csrReadData, rxData} = '0;
      irqHoldoffCycles = 8'h03;
      void'($urandom(32'he2bfb80f));
      for (int s = 0; s < 2; s++)
      begin
         speedSelect = s[0];
         doReset();
         @(negedge mclk);
         speedSelect = !s[0];
         crossoverDetectEnable = 1'($urandom);
         repeat (3) @(negedge mclk);
         chk({default100Mbps, defaultAutoNeg, defaultFullDuplex}, {s[0], s[0], 1'b0}, "straps");
         chk(autoCrossoverOn, crossoverDetectEnable, "crossover");
      end
      $display("straps test done");
      for (int p = 0; p < 2; p++)
      begin
         {bigEndian, fifoSelect, txReady} = {p[0], p[0], 1'b0};
         drops = 0;
         txExp.delete();
         txGot.delete();
         for (int k = 0; k < 3; k++)
         begin
            w = $urandom;
            wa = p[0] ? 6'($urandom) : 6'h08 + 6'($urandom_range(7));
            wordWr(wa, w, 1'b1);
            if (k < 2) txExp.push_back(w);
         end
         repeat (3) @(negedge mclk);
         chk(drops, 1, "tx drops");
         repeat (4) @(negedge mclk) txReady = 1'($urandom);
         txReady = 1;
         repeat (4) @(negedge mclk);
         chk(txGot.size(), 2, "tx count");
         foreach (txExp[i]) chk(txGot[i], txExp[i], "tx word");
      end
      $display("tx test done");
      rxValid = 1;
      for (int p = 0; p < 2; p++)
      begin
         {bigEndian, fifoSelect} = {p[0], p[0]};
         rxData = $urandom;
         pops = 0;
         wordRd(p[0] ? 6'($urandom) : 6'($urandom_range(7)), r);
         chk(r, rxData, "rx word");
         chk(pops, 1, "rx pops");
      end
      fifoSelect = 0;
      $display("rx test done");
      csrGot.delete();
      wa = 6'h10 + 6'($urandom_range(47));
      w = $urandom;
      wordWr(wa, w, 1'b1);
      wordWr(6'($urandom_range(7)), ~w, 1'b1);
      wordWr(wa, ~w, 1'b0);
      lowPowerState = 1;
      wakes = 0;
      wordWr(wa, ~w, 1'b1);
      lowPowerState = 0;
      repeat (3) @(negedge mclk);
      chk(csrGot.size(), 1, "csr writes");
      chk(csrGot[0], {wa, w}, "csr write");
      chk(txGot.size(), 2, "rx window write");
      chk(wakes, 2, "wake pulses");
      csrReadData = $urandom;
      wordRd(wa, r);
      chk(r, csrReadData, "csr read");
      chk(rdAddr, wa, "csr read address");
      $display("csr test done");
      for (int c = 0; c < 4; c++)
      begin
         {irqPushPull, irqPolarityHigh} = c[1:0];
         irqSource = 1;
         repeat (3) @(negedge mclk);
         chk({irqActive, irqOut, irqOeLow}, {1'b1, irqPolarityHigh, 1'b0}, "irq on");
         irqSource = 0;
         repeat (2) @(negedge mclk);
         chk({irqActive, irqOut, irqOeLow}, {1'b0, irqPolarityHigh ^ irqPushPull, !irqPushPull}, "irq off");
         irqSource = 1;
         @(negedge mclk);
         chk(irqActive, 0, "irq hold-off");
         repeat (6) @(negedge mclk);
         chk(irqActive, 1, "irq again");
         irqSource = 0;
         repeat (6) @(negedge mclk);
      end
      $display("irq test done");
      end_of_test();
   end
endmodule : tb_top
